// ### hdl/prsd_pkg.sv
// Package with constants and types for the ramp sensor digitizer.
package prsd_pkg;
  // Timer tick 2 us, period 640 us, at a 200 MHz clock.
  localparam int CLK_MHZ = 200;
  localparam int TICK_NS = 2000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int PERIOD_US = 640;
  localparam int PERIOD_TICKS = (PERIOD_US * 1000) / TICK_NS;
  localparam int HT_W = 10;
  localparam int PR_W = 16;
  localparam logic [HT_W-1:0] HT_MIN = 10'h001;
  localparam logic [HT_W-1:0] HT_RESET = 10'h000;
  // Periods spent at each step so the integrator can settle.
  localparam int SETTLE_PERIODS = 4;
  localparam logic [PR_W-1:0] FULL_SCALE_DEF = 16'h0064;

  typedef enum logic [1:0] {
    PRSD_IDLE = 2'b00,
    PRSD_STEP = 2'b01,
    PRSD_WAIT = 2'b11,
    PRSD_DONE = 2'b10
  } prsd_state_e;
endpackage

// ### hdl/prsd_pwm.sv
// Fixed period pulse generator with programmable high time.
`timescale 1ns/100ps
module prsd_pwm #(
  parameter int TICK_CYC = 400,
  parameter int PERIOD_TICKS = 320,
  parameter int HT_W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [HT_W-1:0] highTime,
  output logic pwmOut,
  output logic periodEnd
);
  logic [15:0] tick_r, tick_nxt;
  logic [HT_W-1:0] pos_r, pos_nxt;
  logic [HT_W-1:0] ht_r, ht_nxt;
  logic out_r, out_nxt;
  logic wrap;

  always_comb begin
    tick_nxt = tick_r + 16'h0001;
    pos_nxt = pos_r;
    ht_nxt = ht_r;
    wrap = 1'b0;
    if (tick_r == 16'(TICK_CYC - 1)) begin
      tick_nxt = 16'h0000;
      if (pos_r == HT_W'(PERIOD_TICKS - 1)) begin
        pos_nxt = '0;
        wrap = 1'b1;
        // New high time is taken only at a period edge to avoid glitches.
        ht_nxt = highTime;
      end else begin
        pos_nxt = pos_r + 1'b1;
      end
    end
    out_nxt = (pos_nxt < ht_nxt);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_r <= 16'h0000;
      pos_r <= '0;
      ht_r <= '0;
      out_r <= 1'b0;
      periodEnd <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      pos_r <= pos_nxt;
      ht_r <= ht_nxt;
      out_r <= out_nxt;
      periodEnd <= wrap;
    end
  end

  assign pwmOut = out_r;

  property p_period;
    @(posedge mclk) disable iff (rst)
      periodEnd |-> pwmOut == (ht_r != '0);
  endproperty
  a_period: assert property (p_period)
    else $error("pulse high with zero high time at period start");
endmodule

// ### hdl/prsd_top.sv
// Ramp sweep digitizer: pulse train, comparator watch, calibration, scaling.
`timescale 1ns/100ps
module prsd_top
  import prsd_pkg::*;
#(
  parameter int SETTLE = prsd_pkg::SETTLE_PERIODS,
  parameter int PWM_TICK_CYC = prsd_pkg::TICK_CYC,
  parameter int PWM_PERIOD_TICKS = prsd_pkg::PERIOD_TICKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic measStart,
  input wire logic calZero,
  input wire logic calFull,
  input wire logic [prsd_pkg::PR_W-1:0] fullScalePressure,
  input wire logic edge_capture_input_pin,
  output logic pulse_compare_output_pin,
  output logic [prsd_pkg::HT_W-1:0] resultHighTime,
  output logic [prsd_pkg::HT_W-1:0] zeroHighTime,
  output logic [prsd_pkg::HT_W-1:0] fullHighTime,
  output logic [prsd_pkg::PR_W-1:0] pressure,
  output logic measDone,
  output logic measFail
);
  import prsd_pkg::*;

  prsd_state_e state_r, state_nxt;
  logic [HT_W-1:0] ht_r, ht_nxt;
  logic [HT_W-1:0] res_r, res_nxt;
  logic [HT_W-1:0] zero_r, zero_nxt;
  logic [HT_W-1:0] full_r, full_nxt;
  logic [PR_W-1:0] pres_r, pres_nxt;
  logic [7:0] settle_r, settle_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic calZ_r, calZ_nxt;
  logic calF_r, calF_nxt;
  logic cmpMeta_r, cmpSync_r;
  logic periodEnd;
  logic fallEdge;

  // Scaled interpolation; zero span gives zero to avoid a divide by zero.
  function automatic logic [PR_W-1:0] scale(
    input logic [HT_W-1:0] cur,
    input logic [HT_W-1:0] z,
    input logic [HT_W-1:0] f,
    input logic [PR_W-1:0] fs
  );
    logic [HT_W+PR_W-1:0] num;
    logic [HT_W-1:0] span;
    logic [HT_W-1:0] off;
    num = '0;
    span = f - z;
    off = (cur > z) ? (cur - z) : '0;
    if (f <= z) begin
      scale = '0;
    end else begin
      num = (HT_W+PR_W)'(off) * (HT_W+PR_W)'(fs);
      scale = PR_W'(num / (HT_W+PR_W)'(span));
    end
  endfunction

  prsd_pwm #(
    .TICK_CYC(PWM_TICK_CYC),
    .PERIOD_TICKS(PWM_PERIOD_TICKS),
    .HT_W(HT_W)
  ) u_pwm (
    .mclk(mclk),
    .rst(rst),
    .highTime(ht_r),
    .pwmOut(pulse_compare_output_pin),
    .periodEnd(periodEnd)
  );

  // Two stage synchroniser; only the second stage is read by logic.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmpMeta_r <= 1'b1;
      cmpSync_r <= 1'b1;
    end else begin
      cmpMeta_r <= edge_capture_input_pin;
      cmpSync_r <= cmpMeta_r;
    end
  end

  // A low level after a settled step counts as the falling transition.
  assign fallEdge = !cmpSync_r;

  always_comb begin
    state_nxt = state_r;
    ht_nxt = ht_r;
    res_nxt = res_r;
    zero_nxt = zero_r;
    full_nxt = full_r;
    pres_nxt = pres_r;
    settle_nxt = settle_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    calZ_nxt = calZ_r;
    calF_nxt = calF_r;
    case (state_r)
      PRSD_IDLE: begin
        if (measStart || calZero || calFull) begin
          ht_nxt = HT_MIN;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          calZ_nxt = calZero;
          calF_nxt = calFull && !calZero;
          // One extra period covers a start that lands on a period edge,
          // where the generator would still load the old high time.
          settle_nxt = 8'(SETTLE + 2);
          state_nxt = PRSD_WAIT;
        end
      end
      PRSD_STEP: begin
        // Raise first; the check follows only after settling.
        if (ht_r == HT_W'(PWM_PERIOD_TICKS)) begin
          fail_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = PRSD_DONE;
        end else begin
          ht_nxt = ht_r + 1'b1;
          // The first period edge only loads the new high time, so it is
          // not counted as a settled period.
          settle_nxt = 8'(SETTLE + 1);
          state_nxt = PRSD_WAIT;
        end
      end
      PRSD_WAIT: begin
        if (periodEnd) begin
          if (settle_r == 8'h01) begin
            if (fallEdge) begin
              res_nxt = ht_r;
              if (calZ_r) begin
                zero_nxt = ht_r;
              end
              if (calF_r) begin
                full_nxt = ht_r;
              end
              pres_nxt = scale(ht_r, zero_r, full_r, fullScalePressure);
              done_nxt = 1'b1;
              state_nxt = PRSD_DONE;
            end else begin
              state_nxt = PRSD_STEP;
            end
          end else begin
            settle_nxt = settle_r - 8'h01;
          end
        end
      end
      PRSD_DONE: begin
        // Recompute with the latest calibration points.
        pres_nxt = scale(res_r, zero_r, full_r, fullScalePressure);
        ht_nxt = HT_RESET;
        if (measStart || calZero || calFull) begin
          done_nxt = 1'b0;
          state_nxt = PRSD_IDLE;
        end
      end
      default: begin
        state_nxt = PRSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= PRSD_IDLE;
      ht_r <= HT_RESET;
      res_r <= '0;
      zero_r <= '0;
      full_r <= '0;
      pres_r <= '0;
      settle_r <= 8'h00;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      calZ_r <= 1'b0;
      calF_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ht_r <= ht_nxt;
      res_r <= res_nxt;
      zero_r <= zero_nxt;
      full_r <= full_nxt;
      pres_r <= pres_nxt;
      settle_r <= settle_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      calZ_r <= calZ_nxt;
      calF_r <= calF_nxt;
    end
  end

  assign resultHighTime = res_r;
  assign zeroHighTime = zero_r;
  assign fullHighTime = full_r;
  assign pressure = pres_r;
  assign measDone = done_r;
  assign measFail = fail_r;

  property p_step_up;
    @(posedge mclk) disable iff (rst)
      (state_r == PRSD_STEP && ht_r != HT_W'(PWM_PERIOD_TICKS))
        |=> ht_r == $past(ht_r) + 1'b1;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("sweep step did not raise high time by one");

  property p_capture;
    @(posedge mclk) disable iff (rst)
      (state_r == PRSD_WAIT && periodEnd && settle_r == 8'h01 && !cmpSync_r)
        |=> resultHighTime == $past(ht_r) && measDone;
  endproperty
  a_capture: assert property (p_capture)
    else $error("reading not latched from high time at edge");

  property p_no_stop_high;
    @(posedge mclk) disable iff (rst)
      (state_r == PRSD_WAIT && periodEnd && settle_r == 8'h01 && cmpSync_r)
        |=> state_r == PRSD_STEP;
  endproperty
  a_no_stop_high: assert property (p_no_stop_high)
    else $error("sweep stopped while comparator was high");

  property p_check_after_raise;
    @(posedge mclk) disable iff (rst)
      state_r == PRSD_STEP |=> state_r != PRSD_DONE || measFail;
  endproperty
  a_check_after_raise: assert property (p_check_after_raise)
    else $error("check happened before raising high time");

  property p_done_hold;
    @(posedge mclk) disable iff (rst)
      (measDone && !measStart && !calZero && !calFull) |=> measDone;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag dropped before next start");

  property p_start_clears;
    @(posedge mclk) disable iff (rst)
      (state_r == PRSD_IDLE && measStart) |=> !measDone && ht_r == HT_MIN;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start did not begin sweep at lowest setting");

  property p_cal_zero;
    @(posedge mclk) disable iff (rst)
      (calZ_r && state_r == PRSD_WAIT && periodEnd && settle_r == 8'h01
        && !cmpSync_r) |=> zeroHighTime == resultHighTime;
  endproperty
  a_cal_zero: assert property (p_cal_zero)
    else $error("zero pressure point not recorded");

  property p_sync;
    @(posedge mclk) disable iff (rst)
      1'b1 |-> ##2 cmpSync_r == $past(edge_capture_input_pin, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("comparator input not synchronised in two stages");

  property p_pressure;
    @(posedge mclk) disable iff (rst)
      (state_r == PRSD_DONE && $past(state_r) == PRSD_DONE)
        |-> pressure == $past(scale(res_r, zero_r, full_r,
                                    fullScalePressure));
  endproperty
  a_pressure: assert property (p_pressure)
    else $error("pressure does not match interpolation");
endmodule

// ### verification/prsd_rc_comparator_model.sv
// Behavioural RC integrator and comparator facing the digitizer.
`timescale 1ns/100ps
module prsd_rc_comparator_model #(
  parameter int TICK_CYC = prsd_pkg::TICK_CYC
) (
  input wire logic mclk,
  input wire logic pulseIn,
  input wire logic [prsd_pkg::HT_W-1:0] sensorTicks,
  output logic compOut
);
  import prsd_pkg::*;
  int highCyc = 0;
  logic pulseLast = 1'b0;
  logic [HT_W-1:0] seenTicks = 10'h000;
  // The integrator is taken as settled at the end of each high time, so the
  // comparator follows the latest complete pulse and lags a step only at full duty, where no pulse ends.
  always @(posedge mclk) begin
    pulseLast <= pulseIn;
    if (pulseIn) begin
      highCyc <= highCyc + 1;
    end else if (pulseLast) begin
      seenTicks <= HT_W'((highCyc + TICK_CYC / 2) / TICK_CYC);
      highCyc <= 0;
    end
  end
  // Pulled up: high while the sensor stays above the integrated level.
  assign compOut = (seenTicks >= sensorTicks) ? 1'b0 : 1'b1;
endmodule

// ### verification/pwm_ramp_sensor_digitizer_test.sv
// Self-checking bench for the ramp sweep digitizer.
`timescale 1ns/100ps
module pwm_ramp_sensor_digitizer_test;
  import prsd_pkg::*;
  // Short tick and period keep the run brief; the logic scales unchanged.
  localparam int TC_B = 4;
  localparam int PT_B = 16;
  localparam int SETTLE_B = 1;
  localparam int PER_CYC = TC_B * PT_B;
  localparam int LIMIT = (PT_B + 2) * (SETTLE_B + 2) * PER_CYC;
  typedef struct {
    logic [1:0] kind;
    logic [HT_W-1:0] thr, res, zero, full;
    logic [PR_W-1:0] pr;
  } prsd_row_s;
  // Kind 0 measures, 1 calibrates zero, 2 calibrates full scale.
  prsd_row_s rows [4] = '{
    '{2'd1, 10'h001, 10'h001, 10'h001, 10'h000, 16'h0000},
    '{2'd2, 10'h003, 10'h003, 10'h001, 10'h003, 16'h0000},
    '{2'd0, 10'h002, 10'h002, 10'h001, 10'h003, 16'h0032},
    '{2'd0, 10'h001, 10'h001, 10'h001, 10'h003, 16'h0000}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic measStart = 1'b0;
  logic calZero = 1'b0;
  logic calFull = 1'b0;
  logic [PR_W-1:0] fullScale = FULL_SCALE_DEF;
  logic [HT_W-1:0] thr = 10'h001;
  logic comp, pin, measDone, measFail;
  logic [HT_W-1:0] resultHighTime, zeroHighTime, fullHighTime;
  logic [PR_W-1:0] pressure;
  int nFail = 0;
  int numChecks = 0;

  always #2.5 mclk = ~mclk;

  prsd_top #(.SETTLE(SETTLE_B), .PWM_TICK_CYC(TC_B),
      .PWM_PERIOD_TICKS(PT_B)) i_dut (
    .mclk(mclk), .rst(rst), .measStart(measStart), .calZero(calZero),
    .calFull(calFull), .fullScalePressure(fullScale),
    .edge_capture_input_pin(comp), .pulse_compare_output_pin(pin),
    .resultHighTime(resultHighTime), .zeroHighTime(zeroHighTime),
    .fullHighTime(fullHighTime), .pressure(pressure),
    .measDone(measDone), .measFail(measFail));

  prsd_rc_comparator_model #(.TICK_CYC(TC_B)) i_model (
    .mclk(mclk), .pulseIn(pin), .sensorTicks(thr), .compOut(comp));

  task automatic stopTest();
    $display("Checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chkHt(input string what, input logic [HT_W-1:0] exp,
      input logic [HT_W-1:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkPr(input string what, input logic [PR_W-1:0] exp,
      input logic [PR_W-1:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Start is held two cycles so a block left in its done state also starts.
  task automatic sweep(input logic [1:0] kind, input logic [HT_W-1:0] t,
      input bit poke);
    int n;
    thr = t;
    measStart = (kind == 2'd0);
    calZero = (kind == 2'd1);
    calFull = (kind == 2'd2);
    repeat (2) @(negedge mclk);
    measStart = 1'b0;
    calZero = 1'b0;
    calFull = 1'b0;
    if (poke) begin
      repeat (PER_CYC / 2) @(negedge mclk);
      calZero = 1'b1;
      @(negedge mclk);
      calZero = 1'b0;
    end
    n = 0;
    while (measDone !== 1'b1 && n < LIMIT) begin
      @(negedge mclk);
      n++;
    end
    repeat (2) @(negedge mclk);
  endtask

  task automatic chkRow(input prsd_row_s r);
    chkBit("measDone", 1'b1, measDone);
    chkBit("measFail", 1'b0, measFail);
    chkHt("result", r.res, resultHighTime);
    chkHt("zero", r.zero, zeroHighTime);
    chkHt("full", r.full, fullHighTime);
    if (r.kind == 2'd0) chkPr("pressure", r.pr, pressure);
  endtask

  initial begin
    repeat (8 * LIMIT) @(posedge mclk);
    nFail++;
    stopTest();
  end

  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    chkBit("pin", 1'b0, pin);
    chkBit("measDone", 1'b0, measDone);
    chkHt("result", 10'h000, resultHighTime);
    $display("TEST reset done");
    foreach (rows[i]) begin
      sweep(rows[i].kind, rows[i].thr, 1'b0);
      chkRow(rows[i]);
      $display("TEST row %0d done", i);
    end
    // A calibration request during a sweep must leave the zero point alone.
    sweep(2'd0, 10'h002, 1'b1);
    chkRow(rows[2]);
    $display("TEST ignored start done");
    // A sensor above full duty never trips the comparator.
    sweep(2'd0, 10'h3ff, 1'b0);
    chkBit("measDone", 1'b1, measDone);
    chkBit("measFail", 1'b1, measFail);
    chkHt("result", 10'h002, resultHighTime);
    $display("TEST full duty done");
    measStart = 1'b1;
    repeat (2) @(negedge mclk);
    measStart = 1'b0;
    repeat (1000) @(negedge mclk);
    chkBit("measDone", 1'b0, measDone);
    chkBit("measFail", 1'b0, measFail);
    rst = 1'b1;
    @(negedge mclk);
    chkBit("pin", 1'b0, pin);
    chkBit("measDone", 1'b0, measDone);
    chkHt("zero", 10'h000, zeroHighTime);
    chkPr("pressure", 16'h0000, pressure);
    rst = 1'b0;
    sweep(2'd0, 10'h002, 1'b0);
    chkHt("result", 10'h002, resultHighTime);
    chkPr("pressure", 16'h0000, pressure);
    $display("TEST mid-sweep reset done");
    stopTest();
  end
endmodule
